// File: pdc_cfg.svh
// constants for the divider configuration block
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

// register indices; byte address is four times the index
`define PDC_IDX_L1_REF      8'h34
`define PDC_IDX_L1_FB       8'h35
`define PDC_IDX_L2_REF      8'h36
`define PDC_IDX_L2_FB       8'h37
`define PDC_IDX_L1_CTL      8'h38

// field positions
`define PDC_REF_MSB         2
`define PDC_REF_LSB         0
`define PDC_FB_MSB          4
`define PDC_FB_LSB          0
`define PDC_POST_MSB        4
`define PDC_POST_LSB        2

// reset values
`define PDC_REF_RST         3'h0
`define PDC_FB_RST          5'h00
`define PDC_POST_RST        3'h7

// post divider: codes below this share the smallest ratio
`define PDC_POST_LOW_CODE   3'h2
`define PDC_POST_LOW_RATIO  4'h2

// bus responses
`define PDC_RESP_OKAY       2'h0
`define PDC_RESP_SLVERR     2'h2

`endif

// File: pdc_pkg.sv
// types of the divider configuration block
`default_nettype none
package pdc_pkg;

    typedef enum logic [2:0] {
        PDC_SEL_NONE   = 3'b000,
        PDC_SEL_L1_REF = 3'b001,
        PDC_SEL_L1_FB  = 3'b010,
        PDC_SEL_L2_REF = 3'b011,
        PDC_SEL_L2_FB  = 3'b100,
        PDC_SEL_L1_CTL = 3'b101
    } pdc_sel_t;

    typedef enum logic [0:0] {
        PDC_WR_IDLE = 1'b0,
        PDC_WR_RESP = 1'b1
    } pdc_wr_t;

    typedef enum logic [0:0] {
        PDC_RD_IDLE = 1'b0,
        PDC_RD_RESP = 1'b1
    } pdc_rd_t;

    typedef struct packed {
        logic [2:0] l1_ref;
        logic [4:0] l1_fb;
        logic [2:0] l2_ref;
        logic [4:0] l2_fb;
        logic [2:0] l1_post;
    } pdc_regs_t;

endpackage : pdc_pkg
`default_nettype wire

// File: pdc_div_decode.sv
// decodes one divide code into bypass flag and ratio
`default_nettype none
module pdc_div_decode #(
    parameter int CODE_W  = 5,
    parameter int RATIO_W = 6
) (
    input  wire logic [CODE_W-1:0]  code,
    output logic                    bypass,
    output logic [RATIO_W-1:0]      ratio
);

    always_comb
    begin
        // code zero bypasses, so it passes the clock at ratio one
        bypass = (code == '0);
        ratio  = RATIO_W'(code) + RATIO_W'(1);
    end

endmodule : pdc_div_decode
`default_nettype wire

// File: pdc_top.sv
// divider configuration registers behind an axi4-lite slave
// Operation
// - loop1 reference code bits 2:0, reset 0; 0 bypass, n divides by n+1.
// - loop1 second code bits 4:0, reset 0; 0 bypass, n divides by n+1.
// - loop2 reference code bits 2:0, reset 0; 0 bypass, n divides by n+1.
// - loop2 second code bits 4:0, reset 0; 0 bypass, n divides by n+1.
// - loop1 post select bits 4:2, reset 7; codes 0,1 give 2, else code+1.
`include "pdc_cfg.svh"
`default_nettype none
module pdc_top #(
    parameter int ADDR_W  = 12,
    parameter int RATIO_W = 6
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [2:0]               loop1_ref_divide_code,
    output logic [4:0]               loop1_second_divide_code,
    output logic [2:0]               loop2_ref_divide_code,
    output logic [4:0]               loop2_second_divide_code,
    output logic [2:0]               loop1_post_divide_select,
    output logic                     loop1_ref_bypass,
    output logic                     loop1_second_bypass,
    output logic                     loop2_ref_bypass,
    output logic                     loop2_second_bypass,
    output logic [RATIO_W-1:0]       loop1_ref_ratio,
    output logic [RATIO_W-1:0]       loop1_second_ratio,
    output logic [RATIO_W-1:0]       loop2_ref_ratio,
    output logic [RATIO_W-1:0]       loop2_second_ratio,
    output logic [3:0]               loop1_post_ratio
);
    import pdc_pkg::*;

    localparam int NDIV = 4;

    typedef struct packed {
        pdc_regs_t                      regs;
        pdc_wr_t                        wr_state;
        pdc_rd_t                        rd_state;
        logic                           aw_held;
        logic                           w_held;
        pdc_sel_t                       aw_sel;
        logic [7:0]                     wbyte;
        logic                           wlane0;
        logic [1:0]                     bresp;
        logic [31:0]                    rdata;
        logic [1:0]                     rresp;
        logic [NDIV-1:0]                bypass;
        logic [NDIV-1:0][RATIO_W-1:0]   ratio;
        logic [3:0]                     post_ratio;
    } pdc_state_t;

    pdc_state_t                     s;
    pdc_state_t                     next_s;
    logic [NDIV-1:0][4:0]           dec_code;
    logic [NDIV-1:0]                dec_bypass;
    logic [NDIV-1:0][RATIO_W-1:0]   dec_ratio;
    logic                           aw_take;
    logic                           w_take;
    logic                           ar_take;
    pdc_sel_t                       wr_sel;
    pdc_sel_t                       rd_sel;
    logic [7:0]                     wr_byte;
    logic                           wr_lane0;

    // low two address bits are ignored; any upper bits set means unmapped
    function automatic pdc_sel_t pdc_decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] idx;
        pdc_sel_t          sel;
        idx = addr >> 2;
        sel = PDC_SEL_NONE;
        if (idx == ADDR_W'(`PDC_IDX_L1_REF))
            sel = PDC_SEL_L1_REF;
        else if (idx == ADDR_W'(`PDC_IDX_L1_FB))
            sel = PDC_SEL_L1_FB;
        else if (idx == ADDR_W'(`PDC_IDX_L2_REF))
            sel = PDC_SEL_L2_REF;
        else if (idx == ADDR_W'(`PDC_IDX_L2_FB))
            sel = PDC_SEL_L2_FB;
        else if (idx == ADDR_W'(`PDC_IDX_L1_CTL))
            sel = PDC_SEL_L1_CTL;
        return sel;
    endfunction : pdc_decode

    // reserved bits are simply not stored, so they read back as zero
    function automatic logic [31:0] pdc_read(input pdc_sel_t sel, input pdc_regs_t r);
        logic [31:0] word;
        word = 32'h0000_0000;
        case (sel)
            PDC_SEL_L1_REF: word = 32'(r.l1_ref);
            PDC_SEL_L1_FB:  word = 32'(r.l1_fb);
            PDC_SEL_L2_REF: word = 32'(r.l2_ref);
            PDC_SEL_L2_FB:  word = 32'(r.l2_fb);
            PDC_SEL_L1_CTL: word = 32'({r.l1_post, 2'h0});
            default:        word = 32'h0000_0000;
        endcase
        return word;
    endfunction : pdc_read

    assign dec_code[0] = 5'(s.regs.l1_ref);
    assign dec_code[1] = s.regs.l1_fb;
    assign dec_code[2] = 5'(s.regs.l2_ref);
    assign dec_code[3] = s.regs.l2_fb;

    // one decoder per reference and second divider; reference codes are zero-extended
    generate
        for (genvar i = 0; i < NDIV; i++)
        begin : g_div
            pdc_div_decode #(
                .CODE_W  (5),
                .RATIO_W (RATIO_W)
            ) u_dec (
                .code    (dec_code[i]),
                .bypass  (dec_bypass[i]),
                .ratio   (dec_ratio[i])
            );
        end
    endgenerate

    // a channel is refused while its payload is held or a response is pending
    assign s_axi_awready = !s.aw_held && (s.wr_state == PDC_WR_IDLE);
    assign s_axi_wready  = !s.w_held && (s.wr_state == PDC_WR_IDLE);
    assign s_axi_arready = (s.rd_state == PDC_RD_IDLE);
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign wr_sel        = aw_take ? pdc_decode(s_axi_awaddr) : s.aw_sel;
    assign wr_byte       = w_take ? s_axi_wdata[7:0] : s.wbyte;
    assign wr_lane0      = w_take ? s_axi_wstrb[0] : s.wlane0;
    assign rd_sel        = pdc_decode(s_axi_araddr);

    always_comb
    begin
        next_s = s;

        // hold whichever half arrives first until the other one comes
        if (aw_take)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_sel  = wr_sel;
        end
        if (w_take)
        begin
            next_s.w_held = 1'b1;
            next_s.wbyte  = wr_byte;
            next_s.wlane0 = wr_lane0;
        end

        case (s.wr_state)
            PDC_WR_IDLE:
            begin
                if ((s.aw_held || aw_take) && (s.w_held || w_take))
                begin
                    next_s.aw_held  = 1'b0;
                    next_s.w_held   = 1'b0;
                    next_s.wr_state = PDC_WR_RESP;
                    next_s.bresp    = (wr_sel == PDC_SEL_NONE) ?
                                      `PDC_RESP_SLVERR : `PDC_RESP_OKAY;
                    // only lane 0 carries register bits; upper lanes are reserved
                    if (wr_lane0)
                    begin
                        case (wr_sel)
                            PDC_SEL_L1_REF:
                                next_s.regs.l1_ref =
                                    wr_byte[`PDC_REF_MSB:`PDC_REF_LSB];
                            PDC_SEL_L1_FB:
                                next_s.regs.l1_fb =
                                    wr_byte[`PDC_FB_MSB:`PDC_FB_LSB];
                            PDC_SEL_L2_REF:
                                next_s.regs.l2_ref =
                                    wr_byte[`PDC_REF_MSB:`PDC_REF_LSB];
                            PDC_SEL_L2_FB:
                                next_s.regs.l2_fb =
                                    wr_byte[`PDC_FB_MSB:`PDC_FB_LSB];
                            PDC_SEL_L1_CTL:
                                next_s.regs.l1_post =
                                    wr_byte[`PDC_POST_MSB:`PDC_POST_LSB];
                            default:
                                next_s.regs = s.regs;
                        endcase
                    end
                end
            end
            PDC_WR_RESP:
            begin
                if (s_axi_bready)
                    next_s.wr_state = PDC_WR_IDLE;
            end
            default:
                next_s.wr_state = PDC_WR_IDLE;
        endcase

        case (s.rd_state)
            PDC_RD_IDLE:
            begin
                if (ar_take)
                begin
                    next_s.rd_state = PDC_RD_RESP;
                    next_s.rdata    = pdc_read(rd_sel, s.regs);
                    next_s.rresp    = (rd_sel == PDC_SEL_NONE) ?
                                      `PDC_RESP_SLVERR : `PDC_RESP_OKAY;
                end
            end
            PDC_RD_RESP:
            begin
                if (s_axi_rready)
                    next_s.rd_state = PDC_RD_IDLE;
            end
            default:
                next_s.rd_state = PDC_RD_IDLE;
        endcase

        // ratio outputs are registered, so they trail a register write by one cycle
        next_s.bypass = dec_bypass;
        next_s.ratio  = dec_ratio;
        if (s.regs.l1_post < `PDC_POST_LOW_CODE)
            next_s.post_ratio = `PDC_POST_LOW_RATIO;
        else
            next_s.post_ratio = 4'(s.regs.l1_post) + 4'h1;

        if (!aresetn)
        begin
            next_s              = '0;
            next_s.regs.l1_ref  = `PDC_REF_RST;
            next_s.regs.l1_fb   = `PDC_FB_RST;
            next_s.regs.l2_ref  = `PDC_REF_RST;
            next_s.regs.l2_fb   = `PDC_FB_RST;
            next_s.regs.l1_post = `PDC_POST_RST;
            next_s.wr_state     = PDC_WR_IDLE;
            next_s.rd_state     = PDC_RD_IDLE;
            next_s.aw_sel       = PDC_SEL_NONE;
            next_s.bypass       = '1;
            next_s.ratio        = {NDIV{RATIO_W'(1)}};
            next_s.post_ratio   = 4'h8;
        end
    end

    always_ff @(posedge aclk)
    begin
        s <= next_s;
    end

    assign s_axi_bvalid             = (s.wr_state == PDC_WR_RESP);
    assign s_axi_bresp              = s.bresp;
    assign s_axi_rvalid             = (s.rd_state == PDC_RD_RESP);
    assign s_axi_rdata              = s.rdata;
    assign s_axi_rresp              = s.rresp;
    assign loop1_ref_divide_code    = s.regs.l1_ref;
    assign loop1_second_divide_code = s.regs.l1_fb;
    assign loop2_ref_divide_code    = s.regs.l2_ref;
    assign loop2_second_divide_code = s.regs.l2_fb;
    assign loop1_post_divide_select = s.regs.l1_post;
    assign loop1_ref_bypass         = s.bypass[0];
    assign loop1_second_bypass      = s.bypass[1];
    assign loop2_ref_bypass         = s.bypass[2];
    assign loop2_second_bypass      = s.bypass[3];
    assign loop1_ref_ratio          = s.ratio[0];
    assign loop1_second_ratio       = s.ratio[1];
    assign loop2_ref_ratio          = s.ratio[2];
    assign loop2_second_ratio       = s.ratio[3];
    assign loop1_post_ratio         = s.post_ratio;

endmodule : pdc_top
`default_nettype wire

// File: pdc_top_monitor.sv
// assertion checker for the divider configuration block
`default_nettype none
module pdc_top_monitor #(
    parameter int ADDR_W  = 12,
    parameter int RATIO_W = 6
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [2:0]         loop1_ref_divide_code,
    input wire logic [4:0]         loop1_second_divide_code,
    input wire logic [2:0]         loop2_ref_divide_code,
    input wire logic [4:0]         loop2_second_divide_code,
    input wire logic [2:0]         loop1_post_divide_select,
    input wire logic               loop1_ref_bypass,
    input wire logic               loop2_second_bypass,
    input wire logic [RATIO_W-1:0] loop1_ref_ratio,
    input wire logic [RATIO_W-1:0] loop1_second_ratio,
    input wire logic [RATIO_W-1:0] loop2_ref_ratio,
    input wire logic [RATIO_W-1:0] loop2_second_ratio,
    input wire logic [3:0]         loop1_post_ratio
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ratio trails its code by one edge
    l1_ref_ratio_a: assert property (
        loop1_ref_ratio == RATIO_W'($past(loop1_ref_divide_code)) + 1'b1
        && loop1_ref_bypass == ($past(loop1_ref_divide_code) == 3'h0))
        else $error("loop1 reference ratio wrong");
    l1_fb_ratio_a: assert property (
        loop1_second_ratio == RATIO_W'($past(loop1_second_divide_code)) + 1'b1)
        else $error("loop1 second ratio wrong");
    l2_ref_ratio_a: assert property (
        loop2_ref_ratio == RATIO_W'($past(loop2_ref_divide_code)) + 1'b1)
        else $error("loop2 reference ratio wrong");
    l2_fb_ratio_a: assert property (
        loop2_second_ratio == RATIO_W'($past(loop2_second_divide_code)) + 1'b1
        && loop2_second_bypass == ($past(loop2_second_divide_code) == 5'h00))
        else $error("loop2 second ratio wrong");
    post_ratio_map_a: assert property (
        loop1_post_ratio == (($past(loop1_post_divide_select) < 3'h2) ? 4'h2
        : {1'b0, $past(loop1_post_divide_select)} + 4'h1))
        else $error("post ratio wrong");
    upper_bits_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid ##0 !s_axi_awready)
        else $error("write response dropped");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
endmodule : pdc_top_monitor

bind pdc_top pdc_top_monitor #(.ADDR_W(ADDR_W), .RATIO_W(RATIO_W)) mon_u (.*);
`default_nettype wire

// File: pdc_tb_top.sv
// testbench for the divider configuration block
`default_nettype none
module pdc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    // ready mostly held high; one scenario stalls bready on purpose
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, loop1_post_ratio;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  loop1_ref_divide_code, loop2_ref_divide_code, loop1_post_divide_select;
    logic [4:0]  loop1_second_divide_code, loop2_second_divide_code;
    logic        loop1_ref_bypass, loop1_second_bypass, loop2_ref_bypass, loop2_second_bypass;
    logic [5:0]  loop1_ref_ratio, loop1_second_ratio, loop2_ref_ratio, loop2_second_ratio;
    logic [11:0] bad [3] = '{12'h0CC, 12'h0E4, 12'h8D0};
    int          n_fail = 0, num_checks = 0, cyc = 0;

    pdc_top dut_u (.*);

    always #5ns aclk = ~aclk;

    task automatic final_report();
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_t;
        logic w_t;
        logic b_t;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b_t = 1'b0;
        while (!b_t)
        begin
            // judge on settled values; they stand until the next rising edge
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t  = s_axi_wvalid && s_axi_wready;
            b_t  = s_axi_bvalid && s_axi_bready;
            r    = s_axi_bresp;
            @(posedge aclk);
            if (aw_t)
                s_axi_awvalid <= 1'b0;
            if (w_t)
                s_axi_wvalid <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t;
        logic r_t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        r_t = 1'b0;
        while (!r_t)
        begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t  = s_axi_rvalid && s_axi_rready;
            d    = s_axi_rdata;
            r    = s_axi_rresp;
            @(posedge aclk);
            if (ar_t)
                s_axi_arvalid <= 1'b0;
        end
    endtask : rd

    task automatic chk_reset();
        logic [31:0] d;
        logic [1:0]  r;
        chk({loop1_ref_divide_code, loop1_second_divide_code, loop2_ref_divide_code,
             loop2_second_divide_code, loop1_post_divide_select},
            {3'h0, 5'h00, 3'h0, 5'h00, 3'h7});
        chk({loop1_ref_bypass, loop1_second_bypass, loop2_ref_bypass, loop2_second_bypass,
             loop1_post_ratio}, {4'hF, 4'h8});
        chk({loop1_ref_ratio, loop1_second_ratio, loop2_ref_ratio, loop2_second_ratio},
            {4{6'h01}});
        for (int i = 0; i < 5; i++)
        begin
            rd(12'h0D0 + 12'(4 * i), d, r);
            chk(d, (i == 4) ? 32'h1C : 32'h0);
            chk(r, 2'h0);
        end
    endtask : chk_reset

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            final_report();
        end
    end

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [11:0] o;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_reset();
        // every code, with reserved bits written as ones
        for (int k = 0; k < 4; k++)
            for (int c = 0; c < (k[0] ? 32 : 8); c++)
            begin
                wr(12'h0D0 + 12'(4 * k), ~(k[0] ? 32'h1F : 32'h7) | 32'(c), 4'hF, r);
                chk(r, 2'h0);
                rd(12'h0D0 + 12'(4 * k), d, r);
                chk(d, 32'(c));
                case (k)
                    0: o = {loop1_ref_bypass, loop1_ref_ratio, 2'h0, loop1_ref_divide_code};
                    1: o = {loop1_second_bypass, loop1_second_ratio, loop1_second_divide_code};
                    2: o = {loop2_ref_bypass, loop2_ref_ratio, 2'h0, loop2_ref_divide_code};
                    default: o = {loop2_second_bypass, loop2_second_ratio,
                                  loop2_second_divide_code};
                endcase
                chk(o, {c == 0, 6'(c + 1), 5'(c)});
            end
        for (int s = 0; s < 8; s++)
        begin
            wr(12'h0E0, ~32'h1C | 32'(s << 2), 4'hF, r);
            rd(12'h0E0, d, r);
            chk(d, 32'(s << 2));
            chk({loop1_post_divide_select, loop1_post_ratio},
                {3'(s), (s < 2) ? 4'h2 : 4'(s + 1)});
        end
        // unmapped places refuse and leave the registers alone
        foreach (bad[i])
        begin
            wr(bad[i], 32'h5, 4'hF, r);
            chk(r, 2'h2);
            rd(bad[i], d, r);
            chk(r, 2'h2);
            chk(d, 32'h0);
        end
        // response held back: bvalid must stand and refuse a new address
        s_axi_bready <= 1'b0;
        fork
            wr(12'h0D4, 32'h3, 4'hF, r);
            begin
                repeat (4) @(posedge aclk);
                s_axi_bready <= 1'b1;
            end
        join
        chk(r, 2'h0);
        rd(12'h0D4, d, r);
        chk(d, 32'h3);
        wr(12'h0D0, 32'h5, 4'h0, r);
        chk(r, 2'h0);
        rd(12'h0D0, d, r);
        chk(d, 32'h7);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_reset();
        final_report();
    end
endmodule : pdc_tb_top
`default_nettype wire
